// ==== dxs_defs.vh ====
`ifndef DXS_DEFS_VH
`define DXS_DEFS_VH

// frame geometry
`define DXS_FRAME_BITS      16
`define DXS_CNT_W           5
// command field, frame bits [1:0]
`define DXS_CMD_LSB         0
`define DXS_CMD_MSB         1
`define DXS_CMD_DAC         2'h0
`define DXS_CMD_SER2PAR     2'h1
`define DXS_CMD_PIN_STATE   2'h2
`define DXS_CMD_PAR2SER     2'h3
// channel or pin address, frame bits [7:4]
`define DXS_ADDR_LSB        4
`define DXS_ADDR_MSB        7
// converter code, frame bits [15:8]
`define DXS_CODE_LSB        8
`define DXS_CODE_MSB        15
// expander output level, frame bit 8
`define DXS_LEVEL_BIT       8
// pin state field and captured inputs, shift_bit_four to shift_bit_fifteen
`define DXS_SHIFT_BIT_FOUR    4
`define DXS_SHIFT_BIT_FIFTEEN 15
// reset values
`define DXS_PIN_STATE_RST   12'h000
`define DXS_DAC_RST         8'h00
`define DXS_PAR_OUT_RST     12'h000
`endif

// ==== dxs_frame.v ====
`include "dxs_defs.vh"

module dxs_frame #(
  parameter CHANNELS = 12,
  parameter DAC_W    = 8
) (
  input  wire                      mclk_in,
  input  wire                      rstn_in,
  input  wire                      sclk_in,
  input  wire                      csn_in,
  input  wire                      si_in,
  input  wire [CHANNELS-1:0]       par_in,
  output reg                       so_out,
  output reg                       so_oe_out,
  output reg  [CHANNELS*DAC_W-1:0] dac_code_out,
  output reg                       dac_update_out,
  output reg  [3:0]                dac_chan_out,
  output reg  [CHANNELS-1:0]       par_out,
  output reg  [CHANNELS-1:0]       pin_state_register_out
);

  // every serial and parallel input passes two flip-flops; edges are found on the second stage only
  wire                sclk_sync;
  wire                csn_sync;
  wire                si_sync;
  wire [CHANNELS-1:0] par_sync;
  wire                sclk_rise;
  wire                sclk_fall;
  wire                cs_fall;
  wire                cs_rise;

  dxs_sync #(
    .WIDTH    (1),
    .RST_LEVEL(1'b0)
  ) i_sclk_sync (
    .mclk_in (mclk_in),
    .rstn_in (rstn_in),
    .async_in(sclk_in),
    .sync_out(sclk_sync)
  );

  // chip select resets high so release never looks like a frame start
  dxs_sync #(
    .WIDTH    (1),
    .RST_LEVEL(1'b1)
  ) i_csn_sync (
    .mclk_in (mclk_in),
    .rstn_in (rstn_in),
    .async_in(csn_in),
    .sync_out(csn_sync)
  );

  // same depth as the clock path keeps data aligned with its sampling edge
  dxs_sync #(
    .WIDTH    (1),
    .RST_LEVEL(1'b0)
  ) i_si_sync (
    .mclk_in (mclk_in),
    .rstn_in (rstn_in),
    .async_in(si_in),
    .sync_out(si_sync)
  );

  dxs_sync #(
    .WIDTH    (CHANNELS),
    .RST_LEVEL(1'b0)
  ) i_par_sync (
    .mclk_in (mclk_in),
    .rstn_in (rstn_in),
    .async_in(par_in),
    .sync_out(par_sync)
  );

  dxs_edge #(
    .IDLE_LEVEL(1'b0)
  ) i_sclk_edge (
    .mclk_in (mclk_in),
    .rstn_in (rstn_in),
    .level_in(sclk_sync),
    .rise_out(sclk_rise),
    .fall_out(sclk_fall)
  );

  dxs_edge #(
    .IDLE_LEVEL(1'b1)
  ) i_csn_edge (
    .mclk_in (mclk_in),
    .rstn_in (rstn_in),
    .level_in(csn_sync),
    .rise_out(cs_rise),
    .fall_out(cs_fall)
  );

  wire in_frame = ~csn_sync;

  reg [`DXS_FRAME_BITS-1:0] shift_reg;
  reg [`DXS_CNT_W-1:0]      bit_cnt;
  reg                       capture_pending;

  // the counter saturates at a full frame, so longer frames keep their last bits
  localparam [31:0] FRAME_BITS = `DXS_FRAME_BITS;

  wire [1:0]  cmd       = shift_reg[`DXS_CMD_MSB:`DXS_CMD_LSB];
  wire [3:0]  addr      = shift_reg[`DXS_ADDR_MSB:`DXS_ADDR_LSB];
  wire [31:0] addr_wide = {{28{1'b0}}, addr};
  wire        full      = (bit_cnt == FRAME_BITS[`DXS_CNT_W-1:0]);
  wire        addr_ok   = (addr_wide < CHANNELS);
  wire       execute  = cs_rise & full;

  // frame shifter
  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      shift_reg <= {`DXS_FRAME_BITS{1'b0}};
      bit_cnt   <= {`DXS_CNT_W{1'b0}};
    end else if (cs_fall) begin
      bit_cnt <= {`DXS_CNT_W{1'b0}};
      if (capture_pending) begin
        shift_reg <= {par_sync, 4'h0};
      end
    end else if (in_frame && sclk_rise) begin
      shift_reg <= {shift_reg[`DXS_FRAME_BITS-2:0], si_sync};
      if (!full) begin
        bit_cnt <= bit_cnt + 1'b1;
      end
    end
  end

  // serial output: first captured bit at frame start, then one per falling clock
  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      so_out    <= 1'b0;
      so_oe_out <= 1'b0;
    end else begin
      so_oe_out <= in_frame;
      if (cs_fall) begin
        so_out <= capture_pending ? par_sync[CHANNELS-1] : shift_reg[`DXS_FRAME_BITS-1];
      end else if (in_frame && sclk_fall) begin
        so_out <= shift_reg[`DXS_FRAME_BITS-1];
      end
    end
  end

  // command execution at chip select rise
  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      capture_pending        <= 1'b0;
      dac_code_out           <= {CHANNELS{`DXS_DAC_RST}};
      dac_update_out         <= 1'b0;
      dac_chan_out           <= 4'h0;
      par_out                <= `DXS_PAR_OUT_RST;
      pin_state_register_out <= `DXS_PIN_STATE_RST;
    end else begin
      dac_update_out <= 1'b0;
      if (cs_fall) begin
        capture_pending <= 1'b0;
      end
      if (execute) begin
        case (cmd)
          `DXS_CMD_DAC: begin
            if (addr_ok) begin
              dac_code_out[addr*DAC_W +: DAC_W] <=
                shift_reg[`DXS_CODE_MSB:`DXS_CODE_LSB];
              dac_chan_out   <= addr;
              dac_update_out <= 1'b1;
            end
          end
          `DXS_CMD_SER2PAR: begin
            if (addr_ok) begin
              par_out[addr] <= shift_reg[`DXS_LEVEL_BIT];
            end
          end
          `DXS_CMD_PIN_STATE: begin
            pin_state_register_out <=
              shift_reg[`DXS_SHIFT_BIT_FIFTEEN:`DXS_SHIFT_BIT_FOUR];
          end
          `DXS_CMD_PAR2SER: begin
            capture_pending <= 1'b1;
          end
          default: begin
            capture_pending <= capture_pending;
          end
        endcase
      end
    end
  end

endmodule // dxs_frame

module dxs_sync #(
  parameter       WIDTH     = 1,
  parameter [0:0] RST_LEVEL = 1'b0
) (
  input  wire             mclk_in,
  input  wire             rstn_in,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  // only the second stage leaves this module
  reg [WIDTH-1:0] first_stage;
  reg [WIDTH-1:0] second_stage;

  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      first_stage  <= {WIDTH{RST_LEVEL}};
      second_stage <= {WIDTH{RST_LEVEL}};
    end else begin
      first_stage  <= async_in;
      second_stage <= first_stage;
    end
  end

  assign sync_out = second_stage;

endmodule // dxs_sync

module dxs_edge #(
  parameter [0:0] IDLE_LEVEL = 1'b0
) (
  input  wire mclk_in,
  input  wire rstn_in,
  input  wire level_in,
  output wire rise_out,
  output wire fall_out
);

  // resets to the pin's idle level so leaving reset gives no false edge
  reg level_prev;

  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      level_prev <= IDLE_LEVEL;
    end else begin
      level_prev <= level_in;
    end
  end

  assign rise_out = level_in & ~level_prev;
  assign fall_out = ~level_in & level_prev;

endmodule // dxs_edge

// ==== dxs_checker.sv ====
module dxs_checker #(
  parameter CHANNELS = 12,
  parameter DAC_W    = 8
) (
  input wire                      mclk_in,
  input wire                      rstn_in,
  input wire                      sclk_in,
  input wire                      csn_in,
  input wire                      si_in,
  input wire                      so_out,
  input wire                      so_oe_out,
  input wire                      dac_update_out,
  input wire [CHANNELS-1:0]       par_in,
  input wire [CHANNELS-1:0]       par_out,
  input wire [CHANNELS-1:0]       pin_state_register_out,
  input wire [CHANNELS*DAC_W-1:0] dac_code_out,
  input wire [3:0]                dac_chan_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  oe_idle_a: assert property (csn_in [*6] |-> !so_oe_out) else $error("so on");
  oe_busy_a: assert property (!csn_in [*6] |-> so_oe_out) else $error("so off");
  upd_pulse_a: assert property (dac_update_out |=> !dac_update_out) else $error("long");
  upd_cs_a: assert property (dac_update_out |-> csn_in && $past(csn_in, 2))
    else $error("early update");
  frame_hold_a: assert property (!csn_in [*8] |->
    $stable({dac_code_out, par_out, pin_state_register_out})) else $error("moved");
  chan_ok_a: assert property (dac_update_out |-> dac_chan_out < CHANNELS) else $error("chan");
  chan_hold_a: assert property ($changed(dac_chan_out) |-> dac_update_out)
    else $error("channel moved without update");
  code_upd_a: assert property ($changed(dac_code_out) |-> dac_update_out) else $error("pulse");
  so_hold_a: assert property ($rose(sclk_in) ##1 so_oe_out |=> $stable(so_out) [*3])
    else $error("so moved");
  cover property (dac_update_out);
  cover property (so_oe_out && so_out);
  cover property ($changed(pin_state_register_out));
endmodule // dxs_checker
bind dxs_frame dxs_checker #(.CHANNELS(CHANNELS), .DAC_W(DAC_W)) i_chk (.mclk_in, .rstn_in,
  .sclk_in, .csn_in, .si_in, .so_out, .so_oe_out, .dac_update_out, .par_in, .par_out,
  .pin_state_register_out, .dac_code_out, .dac_chan_out);

// ==== dxs_host.sv ====
module dxs_host (
  input  wire  mclk_in,
  input  wire  so_out,
  output logic sclk_in = 0,
  output logic csn_in  = 1,
  output logic si_in   = 0
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic w(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic frame(input logic [15:0] d, input int n, output logic [15:0] r);
    r = 0;
    csn_in = 0;
    w(8);
    for (int i = n - 1; i >= 0; i--) begin
      si_in = d[i];
      w(4);
      sclk_in = 1;
      w(2);
      r[i] = so_out;
      w(2);
      sclk_in = 0;
    end
    w(4);
    csn_in = 1;
    si_in = ~si_in;
    w(8);
  endtask
endmodule // dxs_host

// ==== dxs_frame_bench.sv ====
module dxs_frame_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 0, rstn_in = 0;
  logic [11:0] par_in = 0, p;
  logic [15:0] w, r;
  logic [119:0] st = 0;
  int seed = 38, miscompares = 0, n_compared = 0;
  int n_upd = 0, n_exp = 0;
  wire sclk_in, csn_in, si_in, so_out, so_oe_out, dac_update_out;
  // a released output shows its inverse, so the host must sample while enabled
  wire so_pin = so_oe_out ? so_out : ~so_out;
  wire [95:0] dac_code_out;
  wire [3:0]  dac_chan_out;
  wire [11:0] par_out, pin_state_register_out;
  wire [119:0] got = {dac_code_out, par_out, pin_state_register_out};
  always #10 mclk_in = ~mclk_in;
  dxs_frame i_dut (.mclk_in, .rstn_in, .sclk_in, .csn_in, .si_in, .par_in, .so_out, .so_oe_out,
    .dac_code_out, .dac_update_out, .dac_chan_out, .par_out, .pin_state_register_out);
  dxs_host i_host (.mclk_in, .so_out(so_pin), .sclk_in, .csn_in, .si_in);
  // an unknown update strobe counts as an extra pulse
  always @(negedge mclk_in) begin
    if (dac_update_out !== 1'b0) begin
      n_upd++;
    end
  end
  function automatic logic [119:0] nxt(logic [119:0] s, logic [15:0] d);
    if (d[1:0] == 0 && d[7:4] < 12) s[24+d[7:4]*8+:8] = d[15:8];
    if (d[1:0] == 1 && d[7:4] < 12) s[12+d[7:4]] = d[8];
    if (d[1:0] == 2) s[11:0] = d[15:4];
    return s;
  endfunction
  task chk(input string nm, input logic [119:0] e, input logic [119:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #500us;
    miscompares++;
    print_verdict;
  end
  initial begin
    repeat (5) @(posedge mclk_in);
    #1 rstn_in = 1;
    i_host.w(4);
    chk("reset", 0, got);
    for (int k = 0; k < 30; k++) begin
      w = $random(seed);
      w[1:0] = k % 3;
      par_in = $random(seed);
      i_host.frame(w, (k == 7) ? 15 : 16, r);
      if (k != 7) st = nxt(st, w);
      if (k != 7 && w[1:0] == 0 && w[7:4] < 12) begin
        n_exp++;
        chk("channel", w[7:4], dac_chan_out);
      end
      chk("updates", n_exp, n_upd);
      chk("state", st, got);
    end
    p = $random(seed);
    par_in = p;
    i_host.frame(16'h0003, 16, r);
    w = $random(seed);
    w[1:0] = 2;
    i_host.frame(w, 16, r);
    st = nxt(st, w);
    chk("capture", {p, 4'h0}, r);
    chk("state", st, got);
    print_verdict;
  end
endmodule // dxs_frame_bench
